/* core/internal_ram_data_port.sv */
`timescale 1ns/1ps
module internal_ram_data_port
  import ram_port_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // axi4-lite slave
  input  wire logic [11:0]                   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [11:0]                   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // shared ram-side port
  output logic                               ram_test_unlock,
  output logic [ram_port_pkg::CHOICE_W-1:0]  ram_choice,
  output logic [3:0]                         ram_req,
  output logic                               ram_we,
  output logic [ram_port_pkg::ADDR_W-1:0]    ram_addr,
  output logic [ram_port_pkg::WORD_W-1:0]    ram_wdata,
  input  wire logic [ram_port_pkg::WORD_W-1:0] ram_rdata,
  input  wire logic                          ram_ack
);
  import ram_port_pkg::*;

  // sequencer states
  // idle: registers open to software, ready flag high
  // access: one request out on the ram side, ready flag low
  // only two states in a 2-bit encoding; the case has no default for the two unused codes
  // the sequencer waits for the ram acknowledge
  // and has no timeout of its own
  // a ram that never acknowledges leaves the port busy
  // until the next reset
  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS} port_state_t;

  // port state
  // every software-visible field has its own flip-flop
  // reserved bits have no storage and read back zero
  port_state_t                 state_q;
  logic                        unlock_q;      // test unlock
  logic [CHOICE_W-1:0]         choice_q;      // selected ram
  logic                        cmd_q;         // last command bit
  logic [ADDR_W-1:0]           addr_q;        // dword address
  logic [31:0]                 low_q;         // data bits 31:0
  logic [HIGH_W-1:0]           high_q;        // data bits 36:32
  logic                        ready_q;       // port ready flag
  // write channel capture
  logic                        aw_have_q;
  logic                        w_have_q;
  logic [11:0]                 awaddr_q;
  logic [31:0]                 wdata_q;
  logic [3:0]                  wstrb_q;
  logic                        wr_fire;       // both halves held
  logic                        wr_hit;
  logic [31:0]                 addr_wr;       // address write merged

  // merge write data into a register honouring byte strobes
  // lanes with a clear strobe keep their old contents
  // used for the address and the low data register
  // single-bit fields check strobe lane 0 directly
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // known register offset
  // shared by the write response, the write decode
  // and the read response, so all three agree
  // on which offsets answer okay
  function automatic logic mapped(input logic [11:0] a);
    return (a == SEL_OFS) || (a == CMD_OFS) || (a == ADDR_OFS) || (a == LOW_OFS) || (a == HIGH_OFS);
  endfunction

  // a write completes once both halves are held
  // and the previous response has been taken
  // the bvalid term stops a second fire on the same pair
  // unmapped writes still fire but change nothing
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_hit  = wr_fire && mapped(awaddr_q);
  // address write merged with the old value, upper bits later cut
  assign addr_wr = merge({17'h0, addr_q}, wdata_q, wstrb_q);

  // write address channel, taken independently of data
  // awready drops on the taking edge
  // and stays low until the response has gone
  // so at most one write address is held at a time
  // ready is raised only from idle, never combinationally
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q     <= 1'b0;
      awaddr_q      <= 12'h000;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q     <= 1'b1;
      awaddr_q      <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_have_q     <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_bvalid;
    end
  end

  // write data channel
  // mirror of the address channel
  // data and strobes are held until the write fires
  // data may arrive before, with or after its address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_have_q     <= 1'b0;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q     <= 1'b1;
      wdata_q      <= s_axi_wdata;
      wstrb_q      <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_have_q     <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_q && !s_axi_bvalid;
    end
  end

  // write response, slverr on unmapped offset
  // raised on the fire cycle, held until bready
  // a command write while busy still answers okay
  // the busy command itself is dropped
  // software sees that through the ready flag only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // select register: unlock and ram choice
  // both fields live in byte lane 0
  // the ready flag in this register is read-only
  // and is kept by the sequencer, not here
  // unlock is not enforced: software must set it first
  // changing the choice during an access does not
  // move the request already out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_q <= UNLOCK_RST;
      choice_q <= CHOICE_RST;
    end else if (wr_hit && awaddr_q == SEL_OFS && wstrb_q[0]) begin
      unlock_q <= wdata_q[UNLOCK_BIT];
      choice_q <= wdata_q[CHOICE_LSB +: CHOICE_W];
    end
  end

  // address register, upper bits dropped
  // dword address, no byte-to-word shift applied
  // bits 31:15 are reserved and never stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= ADDR_RST;
    end else if (wr_hit && awaddr_q == ADDR_OFS) begin
      addr_q <= addr_wr[ADDR_W-1:0];
    end
  end

  // command bit records direction of last access
  // a command written while busy is dropped here too
  // so the read-back always names the running access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= CMD_RST;
    end else if (wr_hit && awaddr_q == CMD_OFS && wstrb_q[0] && state_q == ST_IDLE) begin
      cmd_q <= wdata_q[0];
    end
  end

  // data registers: software writes, ram read result lands
  // the read result wins over a software write in the same cycle
  // direction taken from the request itself, not the register
  // the high register is only meaningful for the queue rams
  // for the narrower rams its bits are passed through as they come
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_q  <= LOW_RST;
      high_q <= HIGH_RST;
    end else if (state_q == ST_ACCESS && ram_ack && !ram_we) begin
      low_q  <= ram_rdata[31:0];
      high_q <= ram_rdata[WORD_W-1:32];
    end else if (wr_hit && awaddr_q == LOW_OFS) begin
      low_q  <= merge(low_q, wdata_q, wstrb_q);
    end else if (wr_hit && awaddr_q == HIGH_OFS && wstrb_q[0]) begin
      high_q <= wdata_q[HIGH_W-1:0];
    end
  end

  // access sequencer; a command write while busy is ignored
  // a command write in idle launches the access
  // address and data are copied from the registers at launch
  // so later register writes cannot disturb the request
  // the request is one-hot, picked by the choice field
  // request, direction, address and data stand until ram_ack
  // ready drops at launch and rises with the acknowledge
  // the read result is stored on that same edge
  // so the flag never shows ready ahead of the data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      ready_q   <= READY_RST;
      ram_req   <= 4'h0;
      ram_we    <= 1'b0;
      ram_addr  <= ADDR_RST;
      ram_wdata <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (wr_hit && awaddr_q == CMD_OFS && wstrb_q[0]) begin
            state_q   <= ST_ACCESS;
            ready_q   <= 1'b0;
            ram_req   <= 4'h1 << choice_q;
            ram_we    <= wdata_q[0];
            ram_addr  <= addr_q;
            ram_wdata <= {high_q, low_q};
          end
        end
        ST_ACCESS: begin
          if (ram_ack) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
            ram_req <= 4'h0;
            ram_we  <= 1'b0;
          end
        end
      endcase
    end
  end

  // unlock mirrored to every ram at once
  // registered once more so the outputs come from flip-flops
  // these pins follow the register one cycle late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_test_unlock <= UNLOCK_RST;
      ram_choice      <= CHOICE_RST;
    end else begin
      ram_test_unlock <= unlock_q;
      ram_choice      <= choice_q;
    end
  end

  // read channel, one cycle latency, reserved bits zero
  // arready high in idle, dropped while a response stands
  // data are chosen on the taking edge and then held
  // the ready flag is read live, so polling sees busy
  // unmapped offsets answer slverr with zero data
  // no wait states beyond the single response cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        SEL_OFS:  s_axi_rdata <= {ready_q, 28'h0, choice_q, unlock_q};
        CMD_OFS:  s_axi_rdata <= {31'h0, cmd_q};
        ADDR_OFS: s_axi_rdata <= {17'h0, addr_q};
        LOW_OFS:  s_axi_rdata <= low_q;
        HIGH_OFS: s_axi_rdata <= {27'h0, high_q};
        default:  s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule

/* core/ram_port_pkg.sv */
package ram_port_pkg;
  // register byte offsets
  localparam logic [11:0] SEL_OFS      = 12'h040;
  localparam logic [11:0] CMD_OFS      = 12'h044;
  localparam logic [11:0] ADDR_OFS     = 12'h048;
  localparam logic [11:0] LOW_OFS      = 12'h04C;
  localparam logic [11:0] HIGH_OFS     = 12'h050;
  // field positions and widths
  localparam int          READY_BIT    = 31;
  localparam int          UNLOCK_BIT   = 0;
  localparam int          CHOICE_LSB   = 1;
  localparam int          CHOICE_W     = 2;
  localparam int          ADDR_W       = 15;
  localparam int          HIGH_W       = 5;
  localparam int          WORD_W       = 37;
  // reset values
  localparam logic        READY_RST    = 1'b1;
  localparam logic        UNLOCK_RST   = 1'b0;
  localparam logic [1:0]  CHOICE_RST   = 2'h0;
  localparam logic [14:0] ADDR_RST     = 15'h0000;
  localparam logic [31:0] LOW_RST      = 32'h0000_0000;
  localparam logic [4:0]  HIGH_RST     = 5'h00;
  localparam logic        CMD_RST      = 1'b0;
  // ram choice encodings
  localparam logic [1:0]  RAM_FRAME    = 2'h0;
  localparam logic [1:0]  RAM_EEPROM   = 2'h1;
  localparam logic [1:0]  RAM_TXQ      = 2'h2;
  localparam logic [1:0]  RAM_RXQ      = 2'h3;
  // axi responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

/* dv/ram_port_chk.sv */
`timescale 1ns/1ps
module ram_port_chk
  import ram_port_pkg::*;
(
  input wire logic                              clk,
  input wire logic                              rst_n,
  input wire logic [11:0]                       s_axi_awaddr,
  input wire logic                              s_axi_awvalid,
  input wire logic                              s_axi_awready,
  input wire logic                              s_axi_wvalid,
  input wire logic                              s_axi_wready,
  input wire logic                              s_axi_bvalid,
  input wire logic                              s_axi_bready,
  input wire logic                              s_axi_rvalid,
  input wire logic                              s_axi_rready,
  input wire logic                              ram_test_unlock,
  input wire logic [ram_port_pkg::CHOICE_W-1:0] ram_choice,
  input wire logic [3:0]                        ram_req,
  input wire logic                              ram_we,
  input wire logic [ram_port_pkg::ADDR_W-1:0]   ram_addr,
  input wire logic [ram_port_pkg::WORD_W-1:0]   ram_wdata,
  input wire logic                              ram_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // command write, taken on both channels at once, launches a request
  property p_start;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == CMD_OFS
      && ram_req == 4'h0 |-> ##[1:3] ram_req != 4'h0;
  endproperty
  a_start: assert property (p_start) else $error("command write started no access");
  // request goes only to the chosen ram
  property p_route;
    ram_req != 4'h0 |-> ram_req == 4'h1 << ram_choice;
  endproperty
  a_route: assert property (p_route) else $error("request to wrong ram");
  property p_onehot;
    $onehot0(ram_req);
  endproperty
  a_onehot: assert property (p_onehot) else $error("more than one ram requested");
  // request and its qualifiers stand until the ram acknowledges
  property p_hold;
    ram_req != 4'h0 && !ram_ack |=> $stable(ram_req) && $stable(ram_we) && $stable(ram_addr) && $stable(ram_wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped before acknowledge");
  property p_release;
    ram_req != 4'h0 && ram_ack |=> ram_req == 4'h0;
  endproperty
  a_release: assert property (p_release) else $error("request kept after acknowledge");
  // one response for each taken transfer
  property p_bonce;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bonce: assert property (p_bonce) else $error("write response repeated");
  property p_ronce;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_ronce: assert property (p_ronce) else $error("read response repeated");
  // unlock and choice only move after a register write
  property p_quiet;
    !s_axi_wvalid [*4] |-> $stable(ram_test_unlock) && $stable(ram_choice);
  endproperty
  a_quiet: assert property (p_quiet) else $error("select field moved without a write");
  c_write: cover property (ram_req != 4'h0 && ram_we && ram_ack);
  c_read: cover property (ram_req != 4'h0 && !ram_we && ram_ack);
  c_busy: cover property (s_axi_bvalid && ram_req != 4'h0);
endmodule
bind internal_ram_data_port ram_port_chk u_chk (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ram_test_unlock(ram_test_unlock),
  .ram_choice(ram_choice), .ram_req(ram_req), .ram_we(ram_we), .ram_addr(ram_addr),
  .ram_wdata(ram_wdata), .ram_ack(ram_ack));

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
  import ram_port_pkg::*;
  logic        clk = 1'h0, rst_n = 1'h0, ram_ack = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, a, lo, hi, d;
  logic [3:0]  s_axi_wstrb = 4'hF, ram_req;
  logic [36:0] ram_rdata = '0, ram_wdata, wd;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ram_test_unlock, ram_we;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ram_choice, r, b;
  logic [14:0] ram_addr;
  logic [31:0] seed = 32'h0001_7254;  // xorshift state
  int          miscompares = 0, checked = 0, cyc = 0;
  internal_ram_data_port dut (.*);
  always #50 clk = ~clk;
  // cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string n, input logic [36:0] s, input logic [36:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  // axi write: address and data offered together, bready held until bvalid
  task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
    @(posedge clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    b = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  // axi read: data and response taken at the rvalid edge
  task automatic rd(input logic [11:0] ad);
    @(posedge clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rchk(input logic [11:0] ad, input logic [31:0] e);
    rd(ad);
    chk($sformatf("reg %h", ad), {r, d}, {RESP_OKAY, e});
  endtask
  task automatic report_and_stop();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    // reset values of all five registers
    for (int i = 0; i < 5; i++) begin
      rchk(SEL_OFS + 12'(4 * i), i == 0 ? 32'h8000_0000 : 32'h0);
    end
    wr(SEL_OFS, '1);
    rchk(SEL_OFS, 32'h8000_0007);
    chk("unlock", ram_test_unlock, 1'h1);
    wr(ADDR_OFS, '1);
    rchk(ADDR_OFS, 32'h0000_7FFF);
    rd(12'h0FC);
    chk("unmapped", {r, d}, {RESP_SLVERR, 32'h0});
    wr(12'h0FC, '1);
    chk("bresp", b, RESP_SLVERR);
    // test mode only, never during normal operation
    wr(SEL_OFS, 32'h1);
    // every ram: one write, then one read with a random delay on the ram side
    for (int c = 0; c < 4; c++) begin
      a = rnd();
      lo = rnd();
      hi = rnd();
      wr(SEL_OFS, {29'h0, c[1:0], 1'h1});
      wr(ADDR_OFS, a);
      wr(LOW_OFS, lo);
      wr(HIGH_OFS, hi);
      for (int w = 1; w >= 0; w--) begin
        wr(CMD_OFS, 32'(w));
        chk("req", {ram_req, ram_we, ram_addr}, {4'h1 << c, w[0], a[14:0]});
        if (w == 1) chk("wdata", ram_wdata, {hi[4:0], lo});
        chk("choice", ram_choice, c[1:0]);
        rchk(SEL_OFS, {29'h0, c[1:0], 1'h1});
        wd = 37'({rnd(), rnd()});
        repeat (rnd() % 4) @(posedge clk);
        ram_rdata <= wd;
        ram_ack <= 1'h1;
        @(posedge clk);
        ram_ack <= 1'h0;
        ram_rdata <= ~wd;
        if (w == 1) wd = {hi[4:0], lo};
        rchk(SEL_OFS, {1'h1, 28'h0, c[1:0], 1'h1});
        rchk(LOW_OFS, wd[31:0]);
        rchk(HIGH_OFS, {27'h0, wd[36:32]});
        rchk(CMD_OFS, 32'(w));
      end
    end
    report_and_stop();
  end
endmodule
